/* src/tcm_pkg.sv */
// package for the touch coordinate mapper: register map, reset values, field layout, carriers
// assumes a single 100 MHz clock and an APB register bus with 32-bit data
//
// What this block does
// - channel counts accepted from 3 to 27 receive and 3 to 19 transmit.
// - 256 positions between adjacent channels, 128 beyond each outer channel centre.
// - default scaling spreads positions across zero to 0x7FFF on each axis.
// - coordinate equals value times two to shift, divided by divisor, plus offset.
// - channel counts per axis held in two separate configuration registers.
// - orientation bit 2 exchanges transmit and receive coordinates.
// - orientation bit 1 reverses the transmit axis.
// - orientation bit 0 reverses the receive axis.
// - every combination of both reversals and exchange is supported.
package tcm_pkg;

    // ----------------------------------------
    // register word indices and address width
    // ----------------------------------------
    localparam logic [11:0] IDX_ORIENT = 12'h041;
    localparam logic [11:0] IDX_RX_SHIFT = 12'h042;
    localparam logic [11:0] IDX_RX_DIV = 12'h043;
    localparam logic [11:0] IDX_RX_BIAS = 12'h044;
    localparam logic [11:0] IDX_TX_SHIFT = 12'h045;
    localparam logic [11:0] IDX_TX_DIV = 12'h046;
    localparam logic [11:0] IDX_TX_BIAS = 12'h047;
    localparam logic [11:0] IDX_HCOUNT = 12'h200;
    localparam logic [11:0] IDX_VCOUNT = 12'h280;
    localparam logic [11:0] IDX_COORD_IN = 12'h300;
    localparam logic [11:0] IDX_COORD_OUT = 12'h301;
    localparam int ADDR_W = 14;

    // ----------------------------------------
    // fields
    // ----------------------------------------
    localparam int ORIENT_SWAP_BIT = 2;
    localparam int ORIENT_TXREV_BIT = 1;
    localparam int ORIENT_RXREV_BIT = 0;
    localparam logic [2:0] ORIENT_MASK = 3'h7;

    // ----------------------------------------
    // grid limits and resolution
    // ----------------------------------------
    localparam logic [7:0] MIN_CH = 8'h03;
    localparam logic [7:0] MAX_RX_CH = 8'h1B;
    localparam logic [7:0] MAX_TX_CH = 8'h13;
    localparam int STEP_PER_CH = 256;
    localparam int EDGE_STEPS = 128;
    localparam logic [15:0] AXIS_MAX = 16'h7FFF;

    // ----------------------------------------
    // reset values: 27 rx and 19 tx, scaled to 0..0x7FFF
    // spans are 27*256 and 19*256; times 2^7 over the count both reach 0x8000, clipped to 0x7FFF
    // ----------------------------------------
    localparam logic [7:0] RST_ORIENT = 8'h00;
    localparam logic [7:0] RST_HCOUNT = 8'h1B;
    localparam logic [7:0] RST_VCOUNT = 8'h13;
    localparam logic [7:0] RST_RX_SHIFT = 8'h07;
    localparam logic [7:0] RST_RX_DIV = 8'h1B;
    localparam logic [7:0] RST_RX_BIAS = 8'h00;
    localparam logic [7:0] RST_TX_SHIFT = 8'h07;
    localparam logic [7:0] RST_TX_DIV = 8'h13;
    localparam logic [7:0] RST_TX_BIAS = 8'h00;

    typedef struct packed {
        logic [7:0] shift;
        logic [7:0] divisor;
        logic [7:0] bias;
    } tcm_scale_type;

    typedef struct packed {
        logic [15:0] rx;
        logic [15:0] tx;
    } tcm_coord_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_DIV = 3'b010,
        ST_DONE = 3'b100
    } tcm_state_type;

endpackage

/* src/tcm_axis_scale.sv */
// one axis: scale by shift and divisor, add bias, clamp, optional reversal
// assumes start is a one-cycle pulse; raw stays put while busy
`timescale 1ns/1ps
`default_nettype none
module tcm_axis_scale
    import tcm_pkg::*;
#(
    parameter int QW = 32
) (
    input wire logic clk_in, // clock
    input wire logic rst_in, // sync reset
    input wire logic start_in, // begin conversion
    input wire logic [15:0] raw_in, // interpolated position
    input wire tcm_scale_type scale_in, // shift divisor bias
    input wire logic reverse_in, // reverse this axis
    output logic busy_out, // conversion running
    output logic [15:0] coord_out // scaled coordinate
);
    tcm_state_type state_r;
    logic [QW-1:0] rem_r;
    logic [QW-1:0] quo_r;
    logic [5:0] cnt_r;
    logic [QW-1:0] dividend;
    logic [QW:0] trial;
    logic [QW-1:0] dvs;
    logic [QW-1:0] sum;
    logic [15:0] clamped;
    logic [15:0] coord_nxt;

    // ----------------------------------------
    // datapath
    // ----------------------------------------
    // shift then divide
    assign dividend = {16'h0000, raw_in} << scale_in.shift[4:0];
    // divisor 0 treated as 1, avoiding a stuck divider
    assign dvs = (scale_in.divisor == 8'h00) ? 32'h1 : {24'h0, scale_in.divisor};
    assign trial = {rem_r, quo_r[QW-1]} - {1'b0, dvs};
    assign sum = quo_r + {24'h0, scale_in.bias};
    assign clamped = (sum > {16'h0, AXIS_MAX}) ? AXIS_MAX : sum[15:0];
    assign coord_nxt = reverse_in ? (AXIS_MAX - clamped) : clamped;
    assign busy_out = (state_r != ST_IDLE);

    // restoring divider, one quotient bit per clock
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_r <= ST_IDLE;
            rem_r <= '0;
            quo_r <= '0;
            cnt_r <= '0;
            coord_out <= '0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (start_in) begin
                        rem_r <= '0;
                        quo_r <= dividend;
                        cnt_r <= 6'(QW);
                        state_r <= ST_DIV;
                    end
                end
                ST_DIV: begin
                    if (trial[QW]) begin
                        rem_r <= {rem_r[QW-2:0], quo_r[QW-1]};
                        quo_r <= {quo_r[QW-2:0], 1'b0};
                    end else begin
                        rem_r <= trial[QW-1:0];
                        quo_r <= {quo_r[QW-2:0], 1'b1};
                    end
                    cnt_r <= cnt_r - 6'd1;
                    if (cnt_r == 6'd1) begin
                        state_r <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    coord_out <= coord_nxt;
                    state_r <= ST_IDLE;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    a_done_follows: assert property (@(posedge clk_in) disable iff (rst_in)
        (state_r == ST_IDLE && start_in) |-> ##(QW+1) (state_r == ST_DONE))
        else $error("divider length wrong");
    a_coord_range: assert property (@(posedge clk_in) disable iff (rst_in)
        coord_out <= AXIS_MAX)
        else $error("coordinate past axis maximum");
endmodule
`default_nettype wire

/* src/tcm_apb_regs.sv */
// apb slave holding the configuration registers of the mapper
// assumes a standard apb master; no wait states, unmapped addresses return slverr
`timescale 1ns/1ps
`default_nettype none
module tcm_apb_regs
    import tcm_pkg::*;
(
    input wire logic clk_in, // clock
    input wire logic rst_in, // sync reset
    input wire logic psel_in, // apb select
    input wire logic penable_in, // apb enable
    input wire logic pwrite_in, // apb direction
    input wire logic [ADDR_W-1:0] paddr_in, // apb byte address
    input wire logic [31:0] pwdata_in, // apb write data
    input wire logic [3:0] pstrb_in, // apb byte strobes
    input wire logic [31:0] status_in, // read-only word, coordinate result
    output logic [31:0] prdata_out, // apb read data
    output logic pslverr_out, // apb error
    output logic [7:0] orient_out, // orientation bits
    output logic [7:0] hcount_out, // horizontal channels
    output logic [7:0] vcount_out, // vertical channels
    output tcm_scale_type rx_scale_out, // receive axis scale
    output tcm_scale_type tx_scale_out, // transmit axis scale
    output logic [31:0] coord_in_out, // raw position word written by software
    output logic coord_go_out // pulse on coordinate word write
);
    logic [11:0] idx;
    logic acc, wr, lane0, hit, ch_ok_h, ch_ok_v;
    logic [7:0] wb;
    logic [31:0] rd;

    assign idx = paddr_in[ADDR_W-1:2];
    assign acc = psel_in && penable_in;
    assign wr = acc && pwrite_in && !pslverr_out;
    assign lane0 = pstrb_in[0];
    assign wb = pwdata_in[7:0];
    assign hit = (idx == IDX_ORIENT) || (idx == IDX_RX_SHIFT) || (idx == IDX_RX_DIV) ||
        (idx == IDX_RX_BIAS) || (idx == IDX_TX_SHIFT) || (idx == IDX_TX_DIV) ||
        (idx == IDX_TX_BIAS) || (idx == IDX_HCOUNT) || (idx == IDX_VCOUNT) ||
        (idx == IDX_COORD_IN) || (idx == IDX_COORD_OUT);
    assign pslverr_out = acc && (!hit || (paddr_in[1:0] != 2'b00));
    assign ch_ok_h = (wb >= MIN_CH) && (wb <= MAX_RX_CH);
    assign ch_ok_v = (wb >= MIN_CH) && (wb <= MAX_TX_CH);
    assign coord_go_out = wr && (idx == IDX_COORD_IN);

    always_comb begin
        rd = 32'h0;
        case (idx)
            IDX_ORIENT: rd = {24'h0, orient_out};
            IDX_RX_SHIFT: rd = {24'h0, rx_scale_out.shift};
            IDX_RX_DIV: rd = {24'h0, rx_scale_out.divisor};
            IDX_RX_BIAS: rd = {24'h0, rx_scale_out.bias};
            IDX_TX_SHIFT: rd = {24'h0, tx_scale_out.shift};
            IDX_TX_DIV: rd = {24'h0, tx_scale_out.divisor};
            IDX_TX_BIAS: rd = {24'h0, tx_scale_out.bias};
            IDX_HCOUNT: rd = {24'h0, hcount_out};
            IDX_VCOUNT: rd = {24'h0, vcount_out};
            IDX_COORD_IN: rd = coord_in_out;
            IDX_COORD_OUT: rd = status_in;
            default: rd = 32'h0;
        endcase
    end
    assign prdata_out = pslverr_out ? 32'h0 : rd;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            orient_out <= RST_ORIENT;
            hcount_out <= RST_HCOUNT;
            vcount_out <= RST_VCOUNT;
            rx_scale_out <= '{RST_RX_SHIFT, RST_RX_DIV, RST_RX_BIAS};
            tx_scale_out <= '{RST_TX_SHIFT, RST_TX_DIV, RST_TX_BIAS};
            coord_in_out <= '0;
        end else if (wr) begin
            if (lane0) begin
                case (idx)
                    IDX_ORIENT: orient_out <= {5'h00, wb[2:0] & ORIENT_MASK};
                    IDX_RX_SHIFT: rx_scale_out.shift <= wb;
                    IDX_RX_DIV: rx_scale_out.divisor <= wb;
                    IDX_RX_BIAS: rx_scale_out.bias <= wb;
                    IDX_TX_SHIFT: tx_scale_out.shift <= wb;
                    IDX_TX_DIV: tx_scale_out.divisor <= wb;
                    IDX_TX_BIAS: tx_scale_out.bias <= wb;
                    IDX_HCOUNT: hcount_out <= ch_ok_h ? wb : hcount_out;
                    IDX_VCOUNT: vcount_out <= ch_ok_v ? wb : vcount_out;
                    default: ;
                endcase
            end
            if (idx == IDX_COORD_IN) begin
                coord_in_out <= pwdata_in;
            end
        end
    end

    a_orient_high_zero: assert property (@(posedge clk_in) disable iff (rst_in)
        orient_out[7:3] == 5'h00)
        else $error("orientation upper bits set");
    a_count_range: assert property (@(posedge clk_in) disable iff (rst_in)
        hcount_out >= MIN_CH && hcount_out <= MAX_RX_CH && vcount_out >= MIN_CH &&
        vcount_out <= MAX_TX_CH)
        else $error("channel count out of range");
    a_count_write: assert property (@(posedge clk_in) disable iff (rst_in)
        (wr && lane0 && idx == IDX_HCOUNT && ch_ok_h) |=> (hcount_out == $past(wb)))
        else $error("horizontal count not stored");
endmodule
`default_nettype wire

/* src/tcm_mapper.sv */
// top of the touch coordinate mapper: apb registers, channel interpolation, two axis scalers, orientation
// assumes sensor positions arrive as channel index plus 8-bit fraction; a plain apb master
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
`default_nettype none
module tcm_mapper
    import tcm_pkg::*;
(
    input wire logic clk_in, // clock 100 MHz
    input wire logic rst_in, // sync reset, active high
    input wire logic psel_in, // apb select
    input wire logic penable_in, // apb enable
    input wire logic pwrite_in, // apb direction
    input wire logic [ADDR_W-1:0] paddr_in, // apb address
    input wire logic [31:0] pwdata_in, // apb write data
    input wire logic [3:0] pstrb_in, // apb strobes
    output logic [31:0] prdata_out, // apb read data
    output logic pready_out, // apb ready
    output logic pslverr_out, // apb error
    input wire logic touch_valid_in, // sensor position strobe
    output logic touch_ready_out, // mapper can take a position
    input wire tcm_coord_type touch_pos_in, // channel index [15:8], fraction [7:0]
    output logic coord_valid_out, // one-cycle pulse, coordinate ready
    output tcm_coord_type coord_out // final x in rx field, y in tx field
);
    logic [7:0] orient, hcount, vcount;
    tcm_scale_type rx_scale, tx_scale;
    logic [31:0] coord_sw;
    logic coord_go, rx_busy, tx_busy, start, pending_r, busy_d_r, swap;
    logic [15:0] rx_raw_r, tx_raw_r, rx_c, tx_c, rx_lin, tx_lin;
    tcm_coord_type pos, result_r;
    logic [31:0] status;

    assign pready_out = 1'b1;

    // ----------------------------------------
    // registers
    // ----------------------------------------
    tcm_apb_regs u_regs (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .psel_in(psel_in),
        .penable_in(penable_in),
        .pwrite_in(pwrite_in),
        .paddr_in(paddr_in),
        .pwdata_in(pwdata_in),
        .pstrb_in(pstrb_in),
        .status_in(status),
        .prdata_out(prdata_out),
        .pslverr_out(pslverr_out),
        .orient_out(orient),
        .hcount_out(hcount),
        .vcount_out(vcount),
        .rx_scale_out(rx_scale),
        .tx_scale_out(tx_scale),
        .coord_in_out(coord_sw),
        .coord_go_out(coord_go)
    );

    // ----------------------------------------
    // interpolation
    // ----------------------------------------
    // a software write takes precedence; the sensor waits through touch_ready_out
    // the word register only lands on this edge, so the position comes straight off the bus
    assign pos = coord_go ? tcm_coord_type'(pwdata_in) : touch_pos_in;
    assign touch_ready_out = !pending_r && !coord_go;
    assign start = coord_go || (touch_valid_in && touch_ready_out);

    // 128 edge steps then 256 per channel, clamped to last channel plus 128
    function automatic logic [15:0] interp(input logic [15:0] p, input logic [7:0] n);
        logic [15:0] lim;
        logic [15:0] v;
        lim = 16'(({8'h00, n} - 16'd1) * STEP_PER_CH + 2 * EDGE_STEPS);
        v = 16'(EDGE_STEPS) + 16'({p[15:8], 8'h00}) + 16'({8'h00, p[7:0]}) - 16'({8'h00, p[7:0]} & 16'h0);
        interp = (v > lim) ? lim : v;
    endfunction

    assign rx_lin = interp(pos.rx, hcount);
    assign tx_lin = interp(pos.tx, vcount);

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rx_raw_r <= '0;
            tx_raw_r <= '0;
            pending_r <= 1'b0;
            busy_d_r <= 1'b0;
        end else begin
            busy_d_r <= rx_busy;
            if (start) begin
                rx_raw_r <= rx_lin;
                tx_raw_r <= tx_lin;
                pending_r <= 1'b1;
            end else if (busy_d_r && !rx_busy) begin
                pending_r <= 1'b0;
            end
        end
    end

    // start the scalers one cycle later so raw registers are settled
    logic go_r;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            go_r <= 1'b0;
        end else begin
            go_r <= start;
        end
    end

    // ----------------------------------------
    // scaling and reversal per axis
    // ----------------------------------------
    // receive reversal, transmit reversal
    tcm_axis_scale u_rx (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .start_in(go_r),
        .raw_in(rx_raw_r),
        .scale_in(rx_scale),
        .reverse_in(orient[ORIENT_RXREV_BIT]),
        .busy_out(rx_busy),
        .coord_out(rx_c)
    );
    tcm_axis_scale u_tx (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .start_in(go_r),
        .raw_in(tx_raw_r),
        .scale_in(tx_scale),
        .reverse_in(orient[ORIENT_TXREV_BIT]),
        .busy_out(tx_busy),
        .coord_out(tx_c)
    );

    // ----------------------------------------
    // exchange and output
    // ----------------------------------------
    // exchange after scaling; all eight combinations independent
    assign swap = orient[ORIENT_SWAP_BIT];
    assign status = result_r;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            result_r <= '0;
            coord_valid_out <= 1'b0;
        end else begin
            coord_valid_out <= busy_d_r && !rx_busy;
            if (busy_d_r && !rx_busy) begin
                result_r <= swap ? '{tx_c, rx_c} : '{rx_c, tx_c};
            end
        end
    end
    assign coord_out = result_r;

    a_swap_apply: assert property (@(posedge clk_in) disable iff (rst_in)
        (busy_d_r && !rx_busy && swap) |=> (coord_out.rx == $past(tx_c)))
        else $error("axis exchange not applied");
    a_no_swap: assert property (@(posedge clk_in) disable iff (rst_in)
        (busy_d_r && !rx_busy && !swap) |=> (coord_out.tx == $past(tx_c)))
        else $error("axes exchanged without request");
    a_result_latency: assert property (@(posedge clk_in) disable iff (rst_in)
        (start && !pending_r) |-> ##36 coord_valid_out)
        else $error("result latency wrong");
    a_pending_block: assert property (@(posedge clk_in) disable iff (rst_in)
        pending_r |-> !touch_ready_out)
        else $error("position taken while busy");
endmodule
`default_nettype wire

/* verification/tcm_sensor_model.sv */
// sensor grid model: presents one interpolated touch position at a time to the mapper
// assumes a one-cycle send request from the bench; holds the position until the mapper takes it
`timescale 1ns/1ps
`default_nettype none
module tcm_sensor_model
    import tcm_pkg::*;
(
    input wire logic clk_in, // clock
    input wire logic rst_in, // sync reset
    input wire logic send_in, // one-cycle request to present a position
    input wire tcm_coord_type pos_in, // position to present
    input wire logic ready_in, // mapper can take a position
    output logic valid_out, // position strobe
    output tcm_coord_type pos_out // position bus
);
    // --------------------------------
    // handshake
    // --------------------------------
    // after a take the bus shows the inverse, so a late sample of a stale word is seen
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            valid_out <= 1'b0;
            pos_out <= '0;
        end else if (valid_out && ready_in) begin
            valid_out <= 1'b0;
            pos_out <= ~pos_out;
        end else if (send_in && !valid_out) begin
            valid_out <= 1'b1;
            pos_out <= pos_in;
        end
    end
endmodule
`default_nettype wire

/* verification/tcm_mapper_tb.sv */
// self-checking bench for the touch coordinate mapper: apb tasks, sensor model, scripted tests
// assumes the package and design files compile first; pready may stretch, the bench waits for it
`timescale 1ns/1ps
`default_nettype none
module tcm_mapper_tb
    import tcm_pkg::*;
;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, send = 1'b0, pready, pslverr, tvalid, tready, cvalid, er;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    tcm_coord_type spos = '0, tpos, coord, got;
    int errors = 0, n_checks = 0;
    int nch[2], sh[2], dv[2], bs[2];
    logic [11:0] ridx[9] = '{IDX_ORIENT, IDX_RX_SHIFT, IDX_RX_DIV, IDX_RX_BIAS, IDX_TX_SHIFT,
        IDX_TX_DIV, IDX_TX_BIAS, IDX_HCOUNT, IDX_VCOUNT};
    logic [7:0] rval[9] = '{RST_ORIENT, RST_RX_SHIFT, RST_RX_DIV, RST_RX_BIAS, RST_TX_SHIFT,
        RST_TX_DIV, RST_TX_BIAS, RST_HCOUNT, RST_VCOUNT};
    logic [7:0] ht[4] = '{8'h03, 8'h02, 8'h1B, 8'h1C};
    logic [7:0] vt[4] = '{8'h03, 8'h02, 8'h13, 8'h14};
    logic [7:0] he[4] = '{8'h03, 8'h03, 8'h1B, 8'h1B};
    logic [7:0] ve[4] = '{8'h03, 8'h03, 8'h13, 8'h13};

    always #5 clk_in = ~clk_in;

    tcm_mapper i_tcm_mapper (
        .clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(4'hF), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .touch_valid_in(tvalid), .touch_ready_out(tready), .touch_pos_in(tpos),
        .coord_valid_out(cvalid), .coord_out(coord)
    );
    tcm_sensor_model i_tcm_sensor_model (
        .clk_in(clk_in), .rst_in(rst_in), .send_in(send), .pos_in(spos), .ready_in(tready),
        .valid_out(tvalid), .pos_out(tpos)
    );

    // --------------------------------
    // tasks and expectations
    // --------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] idx, input logic [31:0] wd,
                       output logic [31:0] rdat, output logic err);
        @(posedge clk_in);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ADDR_W'({idx, 2'b00});
        pwdata <= wd;
        @(posedge clk_in);
        penable <= 1'b1;
        do @(posedge clk_in); while (pready !== 1'b1);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] idx, input logic [31:0] wd);
        apb(1'b1, idx, wd, rd, er);
    endtask

    task automatic rchk(input logic [11:0] idx, input logic [31:0] exp, input string msg);
        apb(1'b0, idx, 32'h0, rd, er);
        chk(rd, exp, msg);
    endtask

    task automatic cfg(input int nr, nt, s0, d0, b0, s1, d1, b1);
        nch = '{nr, nt};
        sh = '{s0, s1};
        dv = '{d0, d1};
        bs = '{b0, b1};
        wr(IDX_HCOUNT, nr);
        wr(IDX_VCOUNT, nt);
        wr(IDX_RX_SHIFT, s0);
        wr(IDX_RX_DIV, d0);
        wr(IDX_RX_BIAS, b0);
        wr(IDX_TX_SHIFT, s1);
        wr(IDX_TX_DIV, d1);
        wr(IDX_TX_BIAS, b1);
    endtask

    function automatic logic [15:0] ax(input int a, input int pos, input logic rv);
        longint v;
        v = 128 + pos;
        if (v > nch[a] * 256) v = nch[a] * 256;
        v = (v << sh[a]) / (dv[a] == 0 ? 1 : dv[a]) + bs[a];
        if (v > 32767) v = 32767;
        if (rv) v = 32767 - v;
        return v[15:0];
    endfunction

    function automatic tcm_coord_type exp_xy(input logic [15:0] rp, tp, input logic [2:0] o);
        logic [15:0] x, y;
        x = ax(0, int'(rp[15:8]) * 256 + int'(rp[7:0]), o[0]);
        y = ax(1, int'(tp[15:8]) * 256 + int'(tp[7:0]), o[1]);
        return o[2] ? {y, x} : {x, y};
    endfunction

    task automatic wait_res();
        int k;
        k = 0;
        do begin
            @(posedge clk_in);
            #1;
            k++;
        end while (cvalid !== 1'b1 && k < 100);
        chk({31'h0, cvalid}, 32'h1, "result strobe");
        got = coord;
    endtask

    task automatic touch(input logic [15:0] rp, tp);
        @(posedge clk_in);
        send <= 1'b1;
        spos <= {rp, tp};
        @(posedge clk_in);
        send <= 1'b0;
        wait_res();
    endtask

    task automatic tchk(input logic [15:0] rp, tp, input logic [2:0] o);
        touch(rp, tp);
        chk(got, exp_xy(rp, tp, o), "mapped coordinate");
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // --------------------------------
    // tests
    // --------------------------------
    initial begin
        repeat (20) @(posedge clk_in);
        rst_in <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            rchk(ridx[i], {24'h0, rval[i]}, "reset value");
        end
        $display("test reset values done");
        wr(IDX_ORIENT, 32'hFF);
        rchk(IDX_ORIENT, 32'h7, "orientation bits");
        wr(IDX_HCOUNT, 32'h14);
        wr(IDX_VCOUNT, 32'h05);
        rchk(IDX_HCOUNT, 32'h14, "horizontal count");
        rchk(IDX_VCOUNT, 32'h05, "vertical count");
        for (int i = 0; i < 4; i++) begin
            wr(IDX_HCOUNT, {24'h0, ht[i]});
            wr(IDX_VCOUNT, {24'h0, vt[i]});
            rchk(IDX_HCOUNT, {24'h0, he[i]}, "horizontal limit");
            rchk(IDX_VCOUNT, {24'h0, ve[i]}, "vertical limit");
        end
        apb(1'b0, 12'h040, 32'h0, rd, er);
        chk({31'h0, er}, 32'h1, "unmapped error");
        wr(IDX_ORIENT, 32'h0);
        $display("test registers done");
        touch(16'h1AFF, 16'h12FF);
        chk(got, 32'h7FFF7FFF, "default full scale");
        $display("test default scale done");
        // the host rewrites every scale field along with the channel counts
        cfg(32'h4, 32'h3, 32'h0, 32'h1, 32'h0, 32'h0, 32'h1, 32'h0);
        touch(16'h00FF, 16'h0000);
        chk(got, 32'h017F0080, "edge and last step");
        touch(16'h0100, 16'h02FF);
        chk(got, 32'h01800300, "next channel and clamp");
        $display("test interpolation done");
        cfg(32'h14, 32'h0A, 32'h3, 32'h7, 32'h10, 32'h2, 32'h5, 32'h21);
        tchk(16'h0A40, 16'h0480, 3'h0);
        tchk(16'h13FF, 16'h0000, 3'h0);
        for (int o = 0; o < 8; o++) begin
            wr(IDX_ORIENT, 32'(o));
            tchk(16'h0A40, 16'h0480, 3'(o));
        end
        $display("test orientation done");
        wr(IDX_ORIENT, 32'h5);
        wr(IDX_COORD_IN, 32'h02300110);
        wait_res();
        rchk(IDX_COORD_OUT, exp_xy(16'h0230, 16'h0110, 3'h5), "register result");
        wr(IDX_ORIENT, 32'h0);
        cfg(32'h1B, 32'h13, 32'h4, 32'h1, 32'h0, 32'h0, 32'h1, 32'hC8);
        tchk(16'h1000, 16'h0100, 3'h0);
        $display("test scaling done");
        results();
    end

    initial begin
        #300000;
        errors++;
        $display("watchdog expired at %0t", $time);
        results();
    end
endmodule
`default_nettype wire
